// ---- src/rotate_arith_skip_ops.v ----
// Datapath for rotates, subtracts, skip, set and nibble swap operations
`include "alu_ops_defines.vh"

// Notes on behaviour
// - Left rotate through carry to memory; carry gets bit 7, bit 0 gets carry.
// - Same left rotate through carry, result to accumulator, memory kept.
// - Right rotate to memory, bit 0 to bit 7, no flags.
// - Right rotate to accumulator, memory and flags unchanged.
// - Right rotate through carry to memory; carry gets bit 0.
// - Right rotate through carry to accumulator; carry gets bit 0.
// - Acc plus inverted memory plus carry into accumulator; flags updated.
// - Acc plus inverted memory plus carry into memory; flags updated.
// - Acc plus inverted memory plus one, to accumulator or memory.
// - Acc plus inverted immediate plus one into accumulator; flags updated.
// - Memory minus one back to memory; skip when zero; no flags.
// - Memory minus one to accumulator; skip when zero.
// - Memory plus one back to memory; skip when zero.
// - Memory plus one to accumulator; skip when zero.
// - Taken skip flushes fetched instruction and adds one dummy cycle.
// - Skip when selected memory bit is one; nothing else changes.
// - Set byte writes all ones to memory, no flags.
// - Set bit forces only the selected bit to one.
// - Nibble swap written back to memory, no flags.
// - Nibble swap into accumulator, memory unchanged.
module rotate_arith_skip_ops (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Instruction from the sequencer
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [2:0] bit_sel,
    input wire [7:0] imm_data,
    // Operands
    input wire [7:0] mem_rdata,
    input wire [7:0] acc_in,
    input wire carry_in,
    // Results
    output reg mem_we_q,
    output reg [7:0] mem_wdata_q,
    output reg acc_we_q,
    output reg [7:0] acc_out_q,
    output reg carry_we_q,
    output reg carry_out_q,
    output reg arith_flags_we_q,
    output reg signed_wrap_flag_q,
    output reg zero_flag_q,
    output reg half_cy_flag_q,
    // Skip control
    output reg skip_q,
    output reg flush_q,
    output reg dummy_q,
    output reg busy_q
);

    // ------------------------------------------------
    // Adder operand select
    // ------------------------------------------------
    reg [7:0] add_b;
    reg add_cin;
    wire [7:0] add_sum;
    wire add_cout;
    wire add_half;
    wire add_ovf;
    always @* begin
        add_b = ~mem_rdata;
        add_cin = 1'b1;
        case (op_code)
            `OP_SUB_CY_ACU, `OP_SUB_CY_MEM: begin
                add_cin = carry_in;
            end
            `OP_SUB_ACU, `OP_SUB_MEM: begin
                add_cin = 1'b1;
            end
            `OP_SUB_IMM: begin
                add_b = ~imm_data;
            end
            default: begin
                add_cin = 1'b1;
            end
        endcase
    end
    sub_adder u_adder (
        .a(acc_in),
        .b(add_b),
        .cin(add_cin),
        .sum(add_sum),
        .cout(add_cout),
        .half(add_half),
        .ovf(add_ovf)
    );

    // ------------------------------------------------
    // Result select
    // ------------------------------------------------
    wire [7:0] rotl_cy_val;
    wire [7:0] rotr_val;
    wire [7:0] rotr_cy_val;
    wire [7:0] dec_val;
    wire [7:0] inc_val;
    wire [7:0] swap_val;
    wire [7:0] bit_mask;
    reg [7:0] res_d;
    reg mem_we_d;
    reg acc_we_d;
    reg carry_we_d;
    reg carry_d;
    reg arith_d;
    reg take_d;
    assign dec_val = mem_rdata - `BYTE_ONE;
    assign inc_val = mem_rdata + `BYTE_ONE;
    assign rotl_cy_val = {mem_rdata[`MSB-1:`LSB], carry_in};
    assign rotr_val = {mem_rdata[`LSB], mem_rdata[`MSB:`LSB+1]};
    assign rotr_cy_val = {carry_in, mem_rdata[`MSB:`LSB+1]};
    assign swap_val = {mem_rdata[`HALF_BIT-1:`LSB], mem_rdata[`MSB:`HALF_BIT]};
    genvar gi;
    generate
        for (gi = 0; gi < `BYTE_W; gi = gi + 1) begin : g_mask
            assign bit_mask[gi] = (bit_sel == gi);
        end
    endgenerate
    always @* begin
        res_d = mem_rdata;
        mem_we_d = 1'b0;
        acc_we_d = 1'b0;
        carry_we_d = 1'b0;
        carry_d = carry_in;
        arith_d = 1'b0;
        take_d = 1'b0;
        case (op_code)
            `OP_ROTL_CY_MEM: begin
                res_d = rotl_cy_val;
                mem_we_d = 1'b1;
                carry_we_d = 1'b1;
                carry_d = mem_rdata[`MSB];
            end
            `OP_ROTL_CY_ACU: begin
                res_d = rotl_cy_val;
                acc_we_d = 1'b1;
                carry_we_d = 1'b1;
                carry_d = mem_rdata[`MSB];
            end
            `OP_ROTR_MEM: begin
                res_d = rotr_val;
                mem_we_d = 1'b1;
            end
            `OP_ROTR_ACU: begin
                res_d = rotr_val;
                acc_we_d = 1'b1;
            end
            `OP_ROTR_CY_MEM: begin
                res_d = rotr_cy_val;
                mem_we_d = 1'b1;
                carry_we_d = 1'b1;
                carry_d = mem_rdata[`LSB];
            end
            `OP_ROTR_CY_ACU: begin
                res_d = rotr_cy_val;
                acc_we_d = 1'b1;
                carry_we_d = 1'b1;
                carry_d = mem_rdata[`LSB];
            end
            `OP_SUB_CY_ACU, `OP_SUB_ACU, `OP_SUB_IMM: begin
                res_d = add_sum;
                acc_we_d = 1'b1;
                carry_we_d = 1'b1;
                carry_d = add_cout;
                arith_d = 1'b1;
            end
            `OP_SUB_CY_MEM, `OP_SUB_MEM: begin
                res_d = add_sum;
                mem_we_d = 1'b1;
                carry_we_d = 1'b1;
                carry_d = add_cout;
                arith_d = 1'b1;
            end
            `OP_DECSKIP_MEM: begin
                res_d = dec_val;
                mem_we_d = 1'b1;
                take_d = (dec_val == `BYTE_ZERO);
            end
            `OP_DECSKIP_ACU: begin
                res_d = dec_val;
                acc_we_d = 1'b1;
                take_d = (dec_val == `BYTE_ZERO);
            end
            `OP_INCSKIP_MEM: begin
                res_d = inc_val;
                mem_we_d = 1'b1;
                take_d = (inc_val == `BYTE_ZERO);
            end
            `OP_INCSKIP_ACU: begin
                res_d = inc_val;
                acc_we_d = 1'b1;
                take_d = (inc_val == `BYTE_ZERO);
            end
            `OP_SKIP_BIT: begin
                take_d = |(mem_rdata & bit_mask);
            end
            `OP_SET_BYTE: begin
                res_d = `BYTE_ALL;
                mem_we_d = 1'b1;
            end
            `OP_SET_BIT: begin
                res_d = mem_rdata | bit_mask;
                mem_we_d = 1'b1;
            end
            `OP_SWAP_MEM: begin
                res_d = swap_val;
                mem_we_d = 1'b1;
            end
            `OP_SWAP_ACU: begin
                res_d = swap_val;
                acc_we_d = 1'b1;
            end
            default: begin
                res_d = mem_rdata;
            end
        endcase
    end

    // ------------------------------------------------
    // Skip sequencing
    // ------------------------------------------------
    wire start;
    wire flush_w;
    wire dummy_w;
    assign start = op_valid && !dummy_w;
    skip_timer u_skip (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(start),
        .take(take_d),
        .flush_q(flush_w),
        .dummy_q(dummy_w)
    );

    // ------------------------------------------------
    // Write enables
    // ------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_we_q <= 1'b0;
            acc_we_q <= 1'b0;
            carry_we_q <= 1'b0;
            arith_flags_we_q <= 1'b0;
        end else begin
            mem_we_q <= start && mem_we_d;
            acc_we_q <= start && acc_we_d;
            carry_we_q <= start && carry_we_d;
            arith_flags_we_q <= start && arith_d;
        end
    end

    // ------------------------------------------------
    // Result bytes and carry
    // ------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_wdata_q <= `BYTE_ZERO;
            acc_out_q <= `BYTE_ZERO;
            carry_out_q <= 1'b0;
        end else begin
            mem_wdata_q <= res_d;
            acc_out_q <= res_d;
            carry_out_q <= carry_d;
        end
    end

    // ------------------------------------------------
    // Arithmetic flags
    // ------------------------------------------------
    wire zero_d;
    assign zero_d = (add_sum == `BYTE_ZERO);
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            signed_wrap_flag_q <= 1'b0;
            zero_flag_q <= 1'b0;
            half_cy_flag_q <= 1'b0;
        end else begin
            signed_wrap_flag_q <= add_ovf;
            zero_flag_q <= zero_d;
            half_cy_flag_q <= add_half;
        end
    end

    // ------------------------------------------------
    // Skip control
    // ------------------------------------------------
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            skip_q <= 1'b0;
            flush_q <= 1'b0;
            dummy_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            skip_q <= start && take_d;
            flush_q <= flush_w;
            dummy_q <= dummy_w;
            busy_q <= start && take_d;
        end
    end
endmodule // rotate_arith_skip_ops

// ---- src/alu_ops_defines.vh ----
// Constants for the rotate, subtract, skip and set datapath
`ifndef ALU_OPS_DEFINES_VH
`define ALU_OPS_DEFINES_VH
// Operation codes
`define OP_W 5
`define OP_NONE 5'h00
`define OP_ROTL_CY_MEM 5'h01
`define OP_ROTL_CY_ACU 5'h02
`define OP_ROTR_MEM 5'h03
`define OP_ROTR_ACU 5'h04
`define OP_ROTR_CY_MEM 5'h05
`define OP_ROTR_CY_ACU 5'h06
`define OP_SUB_CY_ACU 5'h07
`define OP_SUB_CY_MEM 5'h08
`define OP_SUB_ACU 5'h09
`define OP_SUB_MEM 5'h0A
`define OP_SUB_IMM 5'h0B
`define OP_DECSKIP_MEM 5'h0C
`define OP_DECSKIP_ACU 5'h0D
`define OP_INCSKIP_MEM 5'h0E
`define OP_INCSKIP_ACU 5'h0F
`define OP_SKIP_BIT 5'h10
`define OP_SET_BYTE 5'h11
`define OP_SET_BIT 5'h12
`define OP_SWAP_MEM 5'h13
`define OP_SWAP_ACU 5'h14
// Data values
`define BYTE_ZERO 8'h00
`define BYTE_ONE 8'h01
`define BYTE_ALL 8'hFF
`define MSB 7
`define LSB 0
`define HALF_BIT 4
`define BYTE_W 8
`endif

// ---- src/sub_adder.v ----
// Eight-bit adder with carry in, half carry and signed overflow
module sub_adder (
    // Operands
    input wire [7:0] a,
    input wire [7:0] b,
    input wire cin,
    // Results
    output wire [7:0] sum,
    output wire cout,
    output wire half,
    output wire ovf
);
    wire [4:0] lo;
    wire [8:0] full;
    assign lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign sum = full[7:0];
    assign cout = full[8];
    assign half = lo[4];
    assign ovf = (a[7] == b[7]) && (full[7] != a[7]);
endmodule // sub_adder

// ---- src/skip_timer.v ----
// Skip sequencing: flushes the fetched instruction and holds one dummy cycle
`include "alu_ops_defines.vh"
module skip_timer (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Control
    input wire start,
    input wire take,
    // Status
    output reg flush_q,
    output reg dummy_q
);
    localparam ST_IDLE = 2'b01;
    localparam ST_DUMMY = 2'b10;
    reg [1:0] state_q;
    reg [1:0] state_d;
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start && take) state_d = ST_DUMMY;
            end
            ST_DUMMY: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            flush_q <= 1'b0;
            dummy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            flush_q <= (state_q == ST_IDLE) && start && take;
            dummy_q <= (state_d == ST_DUMMY);
        end
    end
endmodule // skip_timer

// ---- testbench/ras_checker_sva.sv ----
// Assertion checker for the rotate, subtract and skip datapath
`include "alu_ops_defines.vh"
module ras_checker (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Operation inputs
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [2:0] bit_sel,
    input wire [7:0] mem_rdata,
    input wire [7:0] acc_in,
    input wire carry_in,
    // Results
    input wire mem_we_q,
    input wire [7:0] mem_wdata_q,
    input wire acc_we_q,
    input wire [7:0] acc_out_q,
    input wire carry_we_q,
    input wire carry_out_q,
    input wire arith_flags_we_q,
    input wire skip_q,
    input wire flush_q,
    input wire dummy_q
);
    timeunit 1ns;
    timeprecision 1ps;
    wire take = op_valid && !skip_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_rotl_mem_result: assert property (take && op_code == `OP_ROTL_CY_MEM |=> mem_we_q
        && carry_we_q && !acc_we_q
        && {carry_out_q, mem_wdata_q} == {$past(mem_rdata), $past(carry_in)})
        else $error("left rotate wrong");
    a_sub_acc_sum: assert property (take && op_code == `OP_SUB_ACU |=> acc_we_q
        && !mem_we_q && arith_flags_we_q
        && {carry_out_q, acc_out_q} == {1'b0, $past(acc_in)} + {1'b0, ~$past(mem_rdata)} + 9'h001)
        else $error("subtract wrong");
    a_inc_skip_zero: assert property (take && op_code == `OP_INCSKIP_MEM |=> mem_we_q
        && !carry_we_q && !arith_flags_we_q && skip_q == ($past(mem_rdata) == 8'hFF))
        else $error("increment skip wrong");
    a_bit_skip_test: assert property (take && op_code == `OP_SKIP_BIT |=> !mem_we_q
        && !acc_we_q && !carry_we_q && skip_q == ($past(mem_rdata) >> $past(bit_sel)) % 2)
        else $error("bit skip wrong");
    a_set_byte_ones: assert property (take && op_code == `OP_SET_BYTE |=> mem_we_q
        && mem_wdata_q == 8'hFF && !carry_we_q && !arith_flags_we_q)
        else $error("set byte wrong");
    a_swap_acc_only: assert property (take && op_code == `OP_SWAP_ACU |=> acc_we_q
        && !mem_we_q && acc_out_q == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])})
        else $error("swap to acc wrong");
    a_skip_dummy_cycle: assert property (skip_q |=> flush_q && dummy_q)
        else $error("no dummy cycle after skip");
    a_skip_refuses_op: assert property (skip_q |=> !mem_we_q && !acc_we_q && !skip_q)
        else $error("op after skip not refused");
endmodule // ras_checker
bind rotate_arith_skip_ops ras_checker chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .op_valid(op_valid), .op_code(op_code), .bit_sel(bit_sel), .mem_rdata(mem_rdata),
    .acc_in(acc_in), .carry_in(carry_in), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q),
    .acc_we_q(acc_we_q), .acc_out_q(acc_out_q), .carry_we_q(carry_we_q),
    .carry_out_q(carry_out_q), .arith_flags_we_q(arith_flags_we_q), .skip_q(skip_q),
    .flush_q(flush_q), .dummy_q(dummy_q));

// ---- testbench/seq_mem_model.sv ----
// Sequencer and data memory byte facing the datapath
module seq_mem_model (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Bench preload
    input wire ld,
    input wire [7:0] ld_mem,
    input wire [7:0] ld_acc,
    input wire ld_cy,
    // Writes from the datapath
    input wire mem_we_q,
    input wire [7:0] mem_wdata_q,
    input wire acc_we_q,
    input wire [7:0] acc_out_q,
    input wire carry_we_q,
    input wire carry_out_q,
    // Operands to the datapath
    output logic [7:0] mem_rdata,
    output logic [7:0] acc_in,
    output logic carry_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Writes land on the edge that sees the enable pulse
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            {mem_rdata, acc_in, carry_in} <= 17'h00000;
        end else if (ld) begin
            {mem_rdata, acc_in, carry_in} <= {ld_mem, ld_acc, ld_cy};
        end else begin
            if (mem_we_q) mem_rdata <= mem_wdata_q;
            if (acc_we_q) acc_in <= acc_out_q;
            if (carry_we_q) carry_in <= carry_out_q;
        end
    end
endmodule // seq_mem_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the rotate, subtract and skip datapath
`include "alu_ops_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic op_valid = 1'b0;
    logic [4:0] op_code = 5'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [7:0] imm_data = 8'h00;
    logic ld = 1'b0;
    logic [7:0] ld_mem = 8'h00;
    logic [7:0] ld_acc = 8'h00;
    logic ld_cy = 1'b0;
    wire [7:0] mem_rdata, acc_in, mem_wdata_q, acc_out_q;
    wire carry_in, mem_we_q, acc_we_q, carry_we_q, carry_out_q, arith_flags_we_q;
    wire signed_wrap_flag_q, zero_flag_q, half_cy_flag_q, skip_q, flush_q, dummy_q, busy_q;
    int errors = 0;
    int compares = 0;
    always #10 clk_sys = ~clk_sys;
    rotate_arith_skip_ops dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .bit_sel(bit_sel), .imm_data(imm_data), .mem_rdata(mem_rdata),
        .acc_in(acc_in), .carry_in(carry_in), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q),
        .acc_we_q(acc_we_q), .acc_out_q(acc_out_q), .carry_we_q(carry_we_q),
        .carry_out_q(carry_out_q), .arith_flags_we_q(arith_flags_we_q),
        .signed_wrap_flag_q(signed_wrap_flag_q), .zero_flag_q(zero_flag_q),
        .half_cy_flag_q(half_cy_flag_q), .skip_q(skip_q), .flush_q(flush_q),
        .dummy_q(dummy_q), .busy_q(busy_q));
    seq_mem_model partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .ld(ld), .ld_mem(ld_mem),
        .ld_acc(ld_acc), .ld_cy(ld_cy), .mem_we_q(mem_we_q), .mem_wdata_q(mem_wdata_q),
        .acc_we_q(acc_we_q), .acc_out_q(acc_out_q), .carry_we_q(carry_we_q),
        .carry_out_q(carry_out_q), .mem_rdata(mem_rdata), .acc_in(acc_in), .carry_in(carry_in));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Model one operation, run it, then probe the refused slot after a skip
    task automatic run_op(input int op, input int m, input int a, input int c);
        int b, s, r, ci, cy, sk, fw, cw, fl, mw, aw, en;
        bit_sel = 3'($urandom_range(7, 0));
        imm_data = 8'($urandom_range(255, 0));
        b = op == 11 ? int'(imm_data) : m;
        ci = op < 9 ? c : 1;
        s = a + (b ^ 255) + ci;
        case (op)
            1, 2: r = (m << 1 | c) & 255;
            3, 4: r = m >> 1 | (m & 1) << 7;
            5, 6: r = m >> 1 | c << 7;
            7, 8, 9, 10, 11: r = s & 255;
            12, 13: r = (m + 255) & 255;
            14, 15: r = (m + 1) & 255;
            17: r = 255;
            18: r = m | 1 << bit_sel;
            19, 20: r = (m << 4 | m >> 4) & 255;
            default: r = m;
        endcase
        fw = op >= 7 && op <= 11;
        cw = op <= 11 && op != 3 && op != 4;
        cy = op < 3 ? m >> 7 : op == 5 || op == 6 ? m & 1 : fw ? s >> 8 : c;
        sk = op == 16 ? m >> bit_sel & 1 : op >= 12 && op <= 15 && r == 0;
        fl = ((a ^ r) & (b ^ 255 ^ r)) >> 7 << 3 | (r == 0 ? 4 : 0);
        fl = fl | ((a & 15) + (~b & 15) + ci) >> 4 << 1 | cy;
        mw = 32'h000E552A >> op & 1;
        aw = 32'h0010AAD4 >> op & 1;
        en = mw << 3 | aw << 2 | cw << 1 | fw;
        @(negedge clk_sys);
        ld = 1'b1;
        {ld_mem, ld_acc, ld_cy} = {8'(m), 8'(a), 1'(c)};
        @(negedge clk_sys);
        ld = 1'b0;
        op_valid = 1'b1;
        op_code = 5'(op);
        @(negedge clk_sys);
        op_valid = 1'(sk);
        op_code = `OP_SET_BYTE;
        check({mem_we_q, acc_we_q, carry_we_q, arith_flags_we_q}, en);
        check({skip_q, busy_q}, sk * 3);
        if (mw | aw) check(mw ? mem_wdata_q : acc_out_q, r);
        if (fw)
            check({signed_wrap_flag_q, zero_flag_q, half_cy_flag_q, carry_out_q}, fl);
        @(negedge clk_sys);
        op_valid = 1'b0;
        check({flush_q, dummy_q}, sk * 3);
        check({mem_we_q, acc_we_q, carry_we_q, arith_flags_we_q, skip_q}, 0);
        @(negedge clk_sys);
        check({carry_in, mem_rdata}, cy << 8 | (mw ? r : m));
        check(acc_in, aw ? r : a);
    endtask
    initial begin
        void'($urandom(32'hF04B3840));
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int op = 1; op <= 20; op++) run_op(op, $urandom_range(255, 0), 85, 1);
        run_op(12, 1, 0, 1);
        run_op(13, 1, 0, 1);
        run_op(14, 255, 0, 1);
        run_op(15, 255, 0, 1);
        run_op(16, 255, 0, 1);
        run_op(9, 0, 0, 1);
        repeat (300) run_op($urandom_range(20, 1), $urandom_range(255, 0),
            $urandom_range(255, 0), $urandom_range(1, 0));
        complete_run;
    end
    initial begin
        #100us;
        errors++;
        complete_run;
    end
endmodule // testbench
